// [verilog/tewpm_pkg.sv]
// ============================================================
// shared constants for the event, window and pulse timer
package tewpm_pkg;

    // counter, period and capture width
    localparam int CNT_W = 16;

    // operating mode codes
    localparam logic [1:0] MODE_EVENT  = 2'h1;
    localparam logic [1:0] MODE_WINDOW = 2'h2;
    localparam logic [1:0] MODE_PULSE  = 2'h3;

    // start control codes
    localparam logic [1:0] START_STOP = 2'h0;
    localparam logic [1:0] START_RISE = 2'h1;
    localparam logic [1:0] WIN_HIGH   = 2'h2;
    localparam logic [1:0] WIN_LOW    = 2'h3;

    // capture edge mode values
    localparam logic CAP_SINGLE = 1'h1;

    // prescaler width and tick masks per source clock select
    localparam int         PRE_W     = 11;
    localparam logic [10:0] DIV_MASK0 = 11'h7FF;
    localparam logic [10:0] DIV_MASK1 = 11'h07F;
    localparam logic [10:0] DIV_MASK2 = 11'h007;
    localparam logic [10:0] DIV_MASK3 = 11'h000;

    // reset values and single-edge load value
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CAP_RST = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    // pulse measurement phases
    typedef enum logic [1:0] {
        PW_WAIT,
        PW_FIRST,
        PW_SECOND
    } tewpm_pw_t;

endpackage

// [verilog/tewpm_pin_if.sv]
`timescale 1ns/1ps
// ============================================================
// synchronised pin state and source clock tick
interface tewpm_pin_if;
    logic level;    // synchronised pin level
    logic rise;     // one-cycle rising edge
    logic fall;     // one-cycle falling edge
    logic src_tick; // one-cycle internal source clock tick

    modport src  (output level, output rise, output fall, output src_tick);
    modport sink (input level, input rise, input fall, input src_tick);
endinterface

// [verilog/tewpm_pin_front.sv]
`timescale 1ns/1ps
// ============================================================
// pin synchroniser, edge detector and source clock prescaler
module tewpm_pin_front (
    input  wire logic       sys_clk,             // system clock
    input  wire logic       rst,                 // async reset, high
    input  wire logic       timer_one_input_pin, // raw input pin
    input  wire logic [1:0] source_clock_select, // prescaler select
    tewpm_pin_if.src        pin                  // to the counter
);

    logic                         sync1;
    logic                         sync2;
    logic                         sync3;
    logic [tewpm_pkg::PRE_W-1:0]  pre;
    logic [tewpm_pkg::PRE_W-1:0]  next_pre;
    logic [tewpm_pkg::PRE_W-1:0]  mask;

    // ============================================================
    // two-stage synchroniser plus history flop for edges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1 <= 1'h0;
            sync2 <= 1'h0;
            sync3 <= 1'h0;
        end else begin
            sync1 <= timer_one_input_pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // edges seen only after the second stage
    assign pin.level = sync2;
    assign pin.rise  = sync2 & ~sync3;
    assign pin.fall  = ~sync2 & sync3;

    // ============================================================
    // free-running prescaler
    always_comb begin
        next_pre = pre + 11'h001;
        unique case (source_clock_select)
            2'h0: mask = tewpm_pkg::DIV_MASK0;
            2'h1: mask = tewpm_pkg::DIV_MASK1;
            2'h2: mask = tewpm_pkg::DIV_MASK2;
            2'h3: mask = tewpm_pkg::DIV_MASK3;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre <= 11'h000;
        end else begin
            pre <= next_pre;
        end
    end

    // tick once per divided period
    assign pin.src_tick = ((pre & mask) == 11'h000);

endmodule

// [verilog/tewpm_timer.sv]
`timescale 1ns/1ps
// ============================================================
// 16-bit event, window and pulse measurement counter
// Overview of operation
// - event mode counts each selected edge of the input pin
// - event mode match with period raises interrupt and clears counter
// - event mode match is checked on the edge opposite the counting edge
// - auto-capture copies live counter into capture register on each counting edge (event) or gated source tick (window)
// - window mode counts gated source ticks, match interrupts and clears
// - window start code 10 counts while high, 11 while low
// - pulse mode starts on trigger edge, then counts source ticks
// - single edge: opposite edge captures, interrupts, sets counter to one, waits trigger
// - double edge: capture both edges, clear only on trigger
// - single edge counter holds at one until next trigger
module tewpm_timer (
    input  wire logic        sys_clk,             // 200 MHz system clock
    input  wire logic        rst,                 // async reset, high
    input  wire logic        timer_one_input_pin, // external pulse pin
    input  wire logic [1:0]  timer_mode,          // 1 event, 2 window, 3 pulse
    input  wire logic [1:0]  start_edge_select,   // 00 stop, else start code
    input  wire logic [1:0]  source_clock_select, // internal source clock
    input  wire logic        auto_capture_enable, // live counter capture
    input  wire logic        capture_edge_mode,   // 1 single, 0 double
    input  wire logic [15:0] period_compare_reg,  // match value
    output logic      [15:0] capture_result_reg,  // captured count
    output logic      [15:0] counter_value,       // live counter
    output logic             timer_match_irq      // one-cycle interrupt
);

    tewpm_pin_if         pin ();
    logic                running;
    logic                trig_edge;
    logic                opp_edge;
    logic                gate;
    logic                at_match;
    logic [15:0]         cnt;
    logic [15:0]         next_cnt;
    logic [15:0]         next_cap;
    logic                next_irq;
    tewpm_pkg::tewpm_pw_t pw;
    tewpm_pkg::tewpm_pw_t next_pw;

    // ============================================================
    // pin front end
    tewpm_pin_front u_front (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .timer_one_input_pin (timer_one_input_pin),
        .source_clock_select (source_clock_select),
        .pin                 (pin)
    );

    // start code decode: 01 rising trigger, 10 or 11 falling
    assign running   = (start_edge_select != tewpm_pkg::START_STOP);
    assign trig_edge = (start_edge_select == tewpm_pkg::START_RISE) ? pin.rise : pin.fall;
    assign opp_edge  = (start_edge_select == tewpm_pkg::START_RISE) ? pin.fall : pin.rise;
    assign gate      = (start_edge_select == tewpm_pkg::WIN_HIGH) ? pin.level : ~pin.level;
    assign at_match  = (cnt == period_compare_reg);

    // ============================================================
    // counter, capture and interrupt next values
    always_comb begin
        next_cnt = cnt;
        next_cap = capture_result_reg;
        next_irq = 1'h0;
        next_pw  = pw;
        if (!running) begin
            next_cnt = tewpm_pkg::CNT_RST;
            next_pw  = tewpm_pkg::PW_WAIT;
        end else begin
            unique case (timer_mode)
                tewpm_pkg::MODE_EVENT: begin
                    if (auto_capture_enable && trig_edge) begin
                        next_cap = cnt;
                    end
                    if (trig_edge) begin
                        next_cnt = cnt + 16'h0001;
                    end else if (opp_edge && at_match) begin
                        next_cnt = tewpm_pkg::CNT_RST;
                        next_irq = 1'h1;
                    end
                end
                tewpm_pkg::MODE_WINDOW: begin
                    if (pin.src_tick && gate) begin
                        if (auto_capture_enable) begin
                            next_cap = cnt;
                        end
                        if (at_match) begin
                            next_cnt = tewpm_pkg::CNT_RST;
                            next_irq = 1'h1;
                        end else begin
                            next_cnt = cnt + 16'h0001;
                        end
                    end
                end
                tewpm_pkg::MODE_PULSE: begin
                    unique case (pw)
                        tewpm_pkg::PW_WAIT: begin
                            if (trig_edge) begin
                                next_pw = tewpm_pkg::PW_FIRST;
                            end
                        end
                        tewpm_pkg::PW_FIRST: begin
                            if (opp_edge) begin
                                next_cap = cnt;
                                next_irq = 1'h1;
                                if (capture_edge_mode == tewpm_pkg::CAP_SINGLE) begin
                                    next_cnt = tewpm_pkg::CNT_ONE;
                                    next_pw  = tewpm_pkg::PW_WAIT;
                                end else begin
                                    next_pw  = tewpm_pkg::PW_SECOND;
                                    if (pin.src_tick) begin
                                        next_cnt = cnt + 16'h0001;
                                    end
                                end
                            end else if (pin.src_tick) begin
                                next_cnt = cnt + 16'h0001;
                            end
                        end
                        tewpm_pkg::PW_SECOND: begin
                            if (trig_edge) begin
                                next_cap = cnt;
                                next_irq = 1'h1;
                                next_cnt = tewpm_pkg::CNT_RST;
                                next_pw  = tewpm_pkg::PW_FIRST;
                            end else if (pin.src_tick) begin
                                next_cnt = cnt + 16'h0001;
                            end
                        end
                    endcase
                end
                default: begin
                    next_cnt = tewpm_pkg::CNT_RST;
                    next_pw  = tewpm_pkg::PW_WAIT;
                end
            endcase
        end
    end

    // ============================================================
    // state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt                <= tewpm_pkg::CNT_RST;
            counter_value      <= tewpm_pkg::CNT_RST;
            capture_result_reg <= tewpm_pkg::CAP_RST;
            timer_match_irq    <= 1'h0;
            pw                 <= tewpm_pkg::PW_WAIT;
        end else begin
            cnt                <= next_cnt;
            counter_value      <= next_cnt;
            capture_result_reg <= next_cap;
            timer_match_irq    <= next_irq;
            pw                 <= next_pw;
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic ev_on;
    logic win_on;
    logic pw_on;
    assign ev_on  = running && (timer_mode == tewpm_pkg::MODE_EVENT);
    assign win_on = running && (timer_mode == tewpm_pkg::MODE_WINDOW);
    assign pw_on  = running && (timer_mode == tewpm_pkg::MODE_PULSE);

    event_count_a: assert property (ev_on && trig_edge |=> cnt == 16'($past(cnt) + 16'h0001))
        else $error("event edge did not advance counter");
    event_match_a: assert property (ev_on && opp_edge && at_match |=> timer_match_irq && cnt == 16'h0000)
        else $error("event match did not interrupt and clear");
    event_edge_a: assert property (ev_on && trig_edge |=> !timer_match_irq)
        else $error("event interrupt on counting edge");
    window_capture_a: assert property (win_on && pin.src_tick && gate && auto_capture_enable
                                       |=> capture_result_reg == $past(cnt))
        else $error("auto capture missed live counter");
    window_match_a: assert property (win_on && pin.src_tick && gate && at_match
                                     |=> timer_match_irq && cnt == 16'h0000)
        else $error("window match did not interrupt and clear");
    window_gate_a: assert property (win_on && !gate |=> $stable(cnt) && !timer_match_irq)
        else $error("window counted while gate closed");
    pulse_start_a: assert property (pw_on && pw == tewpm_pkg::PW_WAIT && !trig_edge ##1 pw_on
                                    |-> $stable(cnt))
        else $error("pulse counter moved before trigger");
    pulse_single_a: assert property (pw_on && pw == tewpm_pkg::PW_FIRST && opp_edge && capture_edge_mode
                                     |=> timer_match_irq && cnt == 16'h0001
                                         && capture_result_reg == $past(cnt))
        else $error("single edge capture wrong");
    pulse_hold_a: assert property (pw_on && pw == tewpm_pkg::PW_FIRST && opp_edge && capture_edge_mode
                                   ##1 (pw_on && !trig_edge) |=> cnt == 16'h0001)
        else $error("single edge counter left hold value");
    pulse_double_a: assert property (pw_on && pw == tewpm_pkg::PW_SECOND && trig_edge
                                     |=> timer_match_irq && cnt == 16'h0000
                                         && capture_result_reg == $past(cnt))
        else $error("double edge trigger capture wrong");
    pulse_keep_a: assert property (pw_on && pw == tewpm_pkg::PW_FIRST && opp_edge && !capture_edge_mode
                                   && pin.src_tick
                                   |=> timer_match_irq && cnt == 16'($past(cnt) + 16'h0001)
                                       && capture_result_reg == $past(cnt))
        else $error("double edge capture lost a count");
    stop_clear_a: assert property (!running |=> cnt == 16'h0000 && !timer_match_irq)
        else $error("stopped counter not clear");

    event_irq_c:  cover property (ev_on && opp_edge && at_match);
    window_irq_c: cover property (win_on && pin.src_tick && gate && at_match);
    double_c:     cover property (pw_on && pw == tewpm_pkg::PW_SECOND && trig_edge);
    single_c:     cover property (pw_on && pw == tewpm_pkg::PW_FIRST && opp_edge && capture_edge_mode);

endmodule

// [verif/tewpm_pulse_src.sv]
`timescale 1ns/1ps
// ============================================================
// external pulse source on the timer input pin
module tewpm_pulse_src (
    input  wire logic sys_clk, // system clock
    output logic      pin      // timer input pin
);
    initial pin = 1'b0;
    // set the idle level of the pin
    task automatic set_level(input logic lvl);
        @(negedge sys_clk);
        pin = lvl;
    endtask
    // n pulses: active level for act cycles, idle level for rest cycles
    // minimum level hold
    task automatic pulses(input int n, input int act, input int rest, input logic idle);
        int a;
        int r;
        a = (act < 2) ? 2 : act;
        r = (rest < 2) ? 2 : rest;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            pin = ~idle;
            repeat (a) @(negedge sys_clk);
            pin = idle;
            repeat (r - 1) @(negedge sys_clk);
        end
    endtask
endmodule

// [verif/tewpm_timer_bench.sv]
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the event, window and pulse timer
module tewpm_timer_bench;
    logic        sys_clk;
    logic        rst;
    wire logic   pin;
    logic [1:0]  mode;
    logic [1:0]  ss;
    logic [1:0]  scs;
    logic        ace;
    logic        cem;
    logic [15:0] per;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic        irq;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] c3;
    int          n_mismatch;
    int          checks;
    int          n_irq;
    int          irq0;

    // clock and time-zero values
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {mode, ss, scs, ace, cem, per} = '0;
        n_mismatch = 0;
        checks = 0;
        n_irq = 0;
    end
    always #2.5 sys_clk = ~sys_clk;

    tewpm_pulse_src i_tewpm_pulse_src (.sys_clk(sys_clk), .pin(pin));
    tewpm_timer i_tewpm_timer (
        .sys_clk(sys_clk), .rst(rst), .timer_one_input_pin(pin), .timer_mode(mode),
        .start_edge_select(ss), .source_clock_select(scs), .auto_capture_enable(ace),
        .capture_edge_mode(cem), .period_compare_reg(per), .capture_result_reg(cap),
        .counter_value(cnt), .timer_match_irq(irq));

    // count interrupt pulses, sampled once settled after the edge
    always @(posedge sys_clk) begin
        #1;
        if (irq === 1'b1) n_irq++;
    end

    // ============================================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (4) @(negedge sys_clk);
    endtask
    // stop, program the controls, then start
    // change only while stopped
    task automatic setup(input logic [1:0] m, input logic [1:0] s, input logic a, input logic e,
                         input logic [15:0] p);
        @(negedge sys_clk);
        ss = tewpm_pkg::START_STOP;
        @(negedge sys_clk);
        mode = m;
        ace = a;
        cem = e;
        per = p;
        scs = 2'h3;
        @(negedge sys_clk);
        ss = s;
        settle();
        irq0 = n_irq;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ============================================================
    // main sequence
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        settle();
        check("counter", cnt, 16'h0000);
        check("capture", cap, 16'h0000);
        $display("test reset done");

        // event mode, rising edges, period three, auto-capture on
        setup(tewpm_pkg::MODE_EVENT, tewpm_pkg::START_RISE, 1'b1, 1'b0, 16'h0003);
        i_tewpm_pulse_src.pulses(2, 4, 4, 1'b0);
        check("counter", cnt, 16'h0002);
        check("capture", cap, 16'h0001);
        fork
            i_tewpm_pulse_src.pulses(1, 6, 4, 1'b0);
            begin
                repeat (5) @(negedge sys_clk);
                check("counter", cnt, 16'h0003);
                check("irq", 16'(n_irq - irq0), 16'h0000);
            end
        join
        check("counter", cnt, 16'h0000);
        check("irq", 16'(n_irq - irq0), 16'h0001);
        check("capture", cap, 16'h0002);
        // stopping clears the counter, capture kept
        @(negedge sys_clk);
        ss = tewpm_pkg::START_STOP;
        settle();
        check("counter", cnt, 16'h0000);
        // falling edges count
        setup(tewpm_pkg::MODE_EVENT, tewpm_pkg::WIN_HIGH, 1'b0, 1'b0, 16'h0010);
        i_tewpm_pulse_src.pulses(2, 4, 4, 1'b0);
        check("counter", cnt, 16'h0002);
        $display("test event done");

        // window mode, count while high, period five
        setup(tewpm_pkg::MODE_WINDOW, tewpm_pkg::WIN_HIGH, 1'b0, 1'b0, 16'h0005);
        i_tewpm_pulse_src.pulses(1, 9, 6, 1'b0);
        check("counter", cnt, 16'h0003);
        check("irq", 16'(n_irq - irq0), 16'h0001);
        // count while low: idle the pin high first
        i_tewpm_pulse_src.set_level(1'b1);
        setup(tewpm_pkg::MODE_WINDOW, tewpm_pkg::WIN_LOW, 1'b0, 1'b0, 16'h0005);
        check("counter", cnt, 16'h0000);
        i_tewpm_pulse_src.pulses(1, 9, 6, 1'b1);
        check("counter", cnt, 16'h0003);
        check("irq", 16'(n_irq - irq0), 16'h0001);
        i_tewpm_pulse_src.set_level(1'b0);
        // slower source clock: one tick per eight cycles, 64 gated cycles
        setup(tewpm_pkg::MODE_WINDOW, tewpm_pkg::START_STOP, 1'b0, 1'b0, 16'h0005);
        scs = 2'h2;
        @(negedge sys_clk);
        ss = tewpm_pkg::WIN_HIGH;
        settle();
        irq0 = n_irq;
        i_tewpm_pulse_src.pulses(1, 64, 6, 1'b0);
        check("counter", cnt, 16'h0002);
        check("irq", 16'(n_irq - irq0), 16'h0001);
        $display("test window done");

        // pulse width, single edge, rising trigger for a high pulse
        // first capture one below the later ones
        setup(tewpm_pkg::MODE_PULSE, tewpm_pkg::START_RISE, 1'b0, tewpm_pkg::CAP_SINGLE, 16'hFFFF);
        i_tewpm_pulse_src.pulses(1, 10, 6, 1'b0);
        c1 = cap;
        check("irq", 16'(n_irq - irq0), 16'h0001);
        check("counter", cnt, 16'h0001);
        i_tewpm_pulse_src.pulses(1, 10, 6, 1'b0);
        c2 = cap;
        i_tewpm_pulse_src.pulses(1, 10, 6, 1'b0);
        c3 = cap;
        check("capture", c2, c1 + 16'h0001);
        check("capture", c3, c2);
        check("irq", 16'(n_irq - irq0), 16'h0003);
        $display("test pulse single done");

        // pulse width, double edge: cycle minus high width is the low width
        setup(tewpm_pkg::MODE_PULSE, tewpm_pkg::START_RISE, 1'b0, 1'b0, 16'hFFFF);
        i_tewpm_pulse_src.pulses(2, 10, 7, 1'b0);
        c1 = cap;
        fork
            i_tewpm_pulse_src.pulses(1, 10, 7, 1'b0);
            begin
                repeat (6) @(negedge sys_clk);
                c2 = cap;
                check("counter", cnt, 16'h0002);
            end
        join
        check("capture", c2 - c1, 16'h0007);
        check("irq", 16'(n_irq - irq0), 16'h0005);
        $display("test pulse double done");
        tally_and_finish();
    end
endmodule
